//--- verilog/idr_pkg.sv
// Constants, register map and carrier types for the inertial data register block
// Overview of operation
// - Power-on reset restores all logic and settings
// - Linear unit soft reset on 0xB6 at 0x14
// - Rotation unit soft reset on 0xB6 at 0x14
// - Soft reset restores defaults, normal mode
// - All outputs in two's complement
// - Linear axes 12 bit, split 11:4 / 3:0
// - Linear low byte bit 0 is fresh-sample flag
// - Low-byte read freezes high byte until read
// - Bit 6 of 0x13 disables shadow lock
// - Bit 7 of 0x13 selects unfiltered data
// - Unfiltered 2 kHz; filtered at twice bandwidth
// - Linear range code in 0x0F bits 3:0
// - Rotation axes 16 bit, split 15:8 / 7:0
// - Rotation decimation 2/5/10/20 then IIR
// - Rotation bandwidth code in 0x10 bits 3:0
// - Rotation range code in 0x0F bits 2:0
// - 8-bit temperature at 0x08 per unit
package idr_pkg;
  localparam logic [7:0] IDR_OFS_X_LOW = 8'h02;
  localparam logic [7:0] IDR_OFS_X_HIGH = 8'h03;
  localparam logic [7:0] IDR_OFS_Y_LOW = 8'h04;
  localparam logic [7:0] IDR_OFS_Y_HIGH = 8'h05;
  localparam logic [7:0] IDR_OFS_Z_LOW = 8'h06;
  localparam logic [7:0] IDR_OFS_Z_HIGH = 8'h07;
  localparam logic [7:0] IDR_OFS_THERMAL = 8'h08;
  localparam logic [7:0] IDR_OFS_SCALE = 8'h0F;
  localparam logic [7:0] IDR_OFS_FILTER = 8'h10;
  localparam logic [7:0] IDR_OFS_PATH = 8'h13;
  localparam logic [7:0] IDR_OFS_SOFT_RESET = 8'h14;
  localparam logic [7:0] IDR_SOFT_RESET_KEY = 8'hB6;
  localparam int IDR_PATH_UNFILT_BIT = 7;
  localparam int IDR_PATH_LOCK_DIS_BIT = 6;
  localparam int IDR_FRESH_BIT = 0;
  localparam logic [7:0] IDR_LIN_SCALE_RST = 8'h03;
  localparam logic [7:0] IDR_LIN_FILTER_RST = 8'h0F;
  localparam logic [7:0] IDR_ROT_SCALE_RST = 8'h00;
  localparam logic [7:0] IDR_ROT_FILTER_RST = 8'h00;
  localparam logic [7:0] IDR_PATH_RST = 8'h00;
  localparam logic [4:0] IDR_LIN_BW_MASK = 5'h1F;
  localparam logic [3:0] IDR_LIN_RANGE_MASK = 4'hF;
  localparam logic [3:0] IDR_ROT_BW_MASK = 4'hF;
  localparam logic [2:0] IDR_ROT_RANGE_MASK = 3'h7;
  localparam int IDR_CLK_HZ = 10000000;
  localparam int IDR_RAW_RATE_HZ = 2000;
  localparam int IDR_RAW_TICK_CYC = IDR_CLK_HZ / IDR_RAW_RATE_HZ;
  localparam int IDR_SOFT_WAIT_MS = 200;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } idr_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [7:0]  temp;
  } idr_sample_t;

  typedef enum logic [1:0] {
    IDR_LOCK_OPEN = 2'b00,
    IDR_LOCK_HELD = 2'b01
  } idr_lock_t;
endpackage

//--- verilog/idr_top.sv
// Register readout for the linear-motion and rotation units
`timescale 1ns/1ps
module idr_top
  import idr_pkg::*;
(
  input wire logic clk_in,               // 10 MHz clock
  input wire logic rstn_in,              // Power-on reset, active low
  input wire idr_req_t lin_req_in,       // Linear unit register request
  input wire idr_req_t rot_req_in,       // Rotation unit register request
  input wire idr_sample_t lin_raw_in,    // Linear front-end sample, offset compensated
  input wire idr_sample_t lin_filt_in,   // Linear filtered sample
  input wire logic lin_filt_valid_in,    // Filtered linear sample strobe
  input wire idr_sample_t rot_raw_in,    // Rotation front-end sample
  input wire idr_sample_t rot_filt_in,   // Rotation decimated and IIR sample
  input wire logic rot_filt_valid_in,    // Filtered rotation sample strobe
  output logic [7:0] lin_rdata_out,      // Linear read data
  output logic [7:0] rot_rdata_out,      // Rotation read data
  output logic [4:0] lin_bw_code_out,    // Linear filter bandwidth code
  output logic [3:0] lin_range_code_out, // Linear range code
  output logic [3:0] rot_bw_code_out,    // Rotation bandwidth code
  output logic [2:0] rot_range_code_out, // Rotation range code
  output logic lin_soft_reset_out,       // Linear soft reset pulse
  output logic rot_soft_reset_out        // Rotation soft reset pulse
);
  logic rst_meta_q;
  logic rstn_q;
  logic [12:0] tick_cnt_q;
  logic raw_tick_q;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rstn_q <= rst_meta_q;
    end
  end

  // Shared 2 kHz enable for unfiltered data in both units
  always_ff @(posedge clk_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      tick_cnt_q <= 13'h0000;
      raw_tick_q <= 1'b0;
    end
    else if (tick_cnt_q == 13'(IDR_RAW_TICK_CYC - 1))
    begin
      tick_cnt_q <= 13'h0000;
      raw_tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 13'h0001;
      raw_tick_q <= 1'b0;
    end
  end

  idr_unit #(.IS_ROT(1'b0)) u_lin (
    .clk_in(clk_in),
    .rstn_in(rstn_q),
    .req_in(lin_req_in),
    .raw_in(lin_raw_in),
    .filt_in(lin_filt_in),
    .filt_valid_in(lin_filt_valid_in),
    .raw_tick_in(raw_tick_q),
    .rdata_out(lin_rdata_out),
    .scale_out(),
    .filter_out(),
    .bw_lin_out(lin_bw_code_out),
    .range_lin_out(lin_range_code_out),
    .bw_rot_out(),
    .range_rot_out(),
    .soft_reset_out(lin_soft_reset_out)
  );

  idr_unit #(.IS_ROT(1'b1)) u_rot (
    .clk_in(clk_in),
    .rstn_in(rstn_q),
    .req_in(rot_req_in),
    .raw_in(rot_raw_in),
    .filt_in(rot_filt_in),
    .filt_valid_in(rot_filt_valid_in),
    .raw_tick_in(raw_tick_q),
    .rdata_out(rot_rdata_out),
    .scale_out(),
    .filter_out(),
    .bw_lin_out(),
    .range_lin_out(),
    .bw_rot_out(rot_bw_code_out),
    .range_rot_out(rot_range_code_out),
    .soft_reset_out(rot_soft_reset_out)
  );
endmodule

// One sensing unit: config registers, shadowed data, fresh flags
module idr_unit
  import idr_pkg::*;
#(
  parameter logic IS_ROT = 1'b0
)
(
  input wire logic clk_in,            // Clock
  input wire logic rstn_in,           // Synchronised reset, active low
  input wire idr_req_t req_in,        // Register request
  input wire idr_sample_t raw_in,     // Unfiltered sample
  input wire idr_sample_t filt_in,    // Filtered sample
  input wire logic filt_valid_in,     // Filtered sample strobe
  input wire logic raw_tick_in,       // 2 kHz enable
  output logic [7:0] rdata_out,       // Read data, registered
  output logic [7:0] scale_out,       // Range register
  output logic [7:0] filter_out,      // Bandwidth register
  output logic [4:0] bw_lin_out,      // Linear bandwidth field
  output logic [3:0] range_lin_out,   // Linear range field
  output logic [3:0] bw_rot_out,      // Rotation bandwidth field
  output logic [2:0] range_rot_out,   // Rotation range field
  output logic soft_reset_out         // Soft reset pulse
);
  // Per-unit defaults, shared by power-on and soft reset
  localparam logic [7:0] SCALE_DFLT = IS_ROT ? IDR_ROT_SCALE_RST : IDR_LIN_SCALE_RST;
  localparam logic [7:0] FILTER_DFLT = IS_ROT ? IDR_ROT_FILTER_RST : IDR_LIN_FILTER_RST;

  logic [7:0] scale_q;
  logic [7:0] filter_q;
  logic [7:0] path_q;
  logic [7:0] scale_d;
  logic [7:0] filter_d;
  logic [7:0] path_d;
  logic soft_q;
  logic [15:0] low_q [3];
  logic [15:0] high_q [3];
  logic [7:0] temp_q;
  logic [2:0] fresh_q;
  idr_lock_t lock_q [3];
  idr_sample_t src;
  logic upd;
  logic lock_en;
  logic [15:0] axis [3];
  logic soft_hit;

  function automatic logic [7:0] low_byte(input logic [15:0] v, input logic f);
    // Linear low nibble in 7:4, fresh flag in bit 0
    if (IS_ROT)
      low_byte = v[7:0];
    else
      low_byte = {v[3:0], 3'b000, f};
  endfunction

  function automatic logic [7:0] high_byte(input logic [15:0] v);
    high_byte = IS_ROT ? v[15:8] : v[11:4];
  endfunction

  // Hit decode for config writes and axis reads; soft reset key decoded apart
  function automatic logic wr_hit(input idr_req_t q, input logic [7:0] a);
    wr_hit = q.wr && q.addr == a;
  endfunction

  function automatic logic rd_hit(input idr_req_t q, input logic [7:0] a);
    rd_hit = q.rd && q.addr == a;
  endfunction

  // Write-only and unmapped offsets read as zero
  function automatic logic [7:0] read_word(input logic [7:0] a);
    case (a)
      IDR_OFS_X_LOW: read_word = low_byte(low_q[0], fresh_q[0]);
      IDR_OFS_X_HIGH: read_word = high_byte(high_q[0]);
      IDR_OFS_Y_LOW: read_word = low_byte(low_q[1], fresh_q[1]);
      IDR_OFS_Y_HIGH: read_word = high_byte(high_q[1]);
      IDR_OFS_Z_LOW: read_word = low_byte(low_q[2], fresh_q[2]);
      IDR_OFS_Z_HIGH: read_word = high_byte(high_q[2]);
      IDR_OFS_THERMAL: read_word = temp_q;
      IDR_OFS_SCALE: read_word = scale_q;
      IDR_OFS_FILTER: read_word = filter_q;
      IDR_OFS_PATH: read_word = path_q;
      default: read_word = 8'h00;
    endcase
  endfunction

  assign soft_hit = req_in.wr && req_in.addr == IDR_OFS_SOFT_RESET
                    && req_in.wdata == IDR_SOFT_RESET_KEY;
  assign lock_en = !path_q[IDR_PATH_LOCK_DIS_BIT];
  // Source select; raw stream paced at 2 kHz
  assign src = path_q[IDR_PATH_UNFILT_BIT] ? raw_in : filt_in;
  assign upd = path_q[IDR_PATH_UNFILT_BIT] ? raw_tick_in : filt_valid_in;
  assign axis[0] = src.x;
  assign axis[1] = src.y;
  assign axis[2] = src.z;

  assign scale_out = scale_q;
  assign filter_out = filter_q;
  assign bw_lin_out = filter_q[4:0] & IDR_LIN_BW_MASK;
  assign range_lin_out = scale_q[3:0] & IDR_LIN_RANGE_MASK;
  assign bw_rot_out = filter_q[3:0] & IDR_ROT_BW_MASK;
  assign range_rot_out = scale_q[2:0] & IDR_ROT_RANGE_MASK;
  assign soft_reset_out = soft_q;

  // Soft reset lands one cycle after the key write; sample path keeps running
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      soft_q <= 1'b0;
    else if (soft_q)
      soft_q <= 1'b0;
    else
      soft_q <= soft_hit;
  end

  // Next config values; a write in the soft reset cycle is lost
  always_comb
  begin
    scale_d = scale_q;
    filter_d = filter_q;
    path_d = path_q;
    if (soft_q)
    begin
      scale_d = SCALE_DFLT;
      filter_d = FILTER_DFLT;
      path_d = IDR_PATH_RST;
    end
    else
    begin
      if (wr_hit(req_in, IDR_OFS_SCALE))
        scale_d = req_in.wdata;
      if (wr_hit(req_in, IDR_OFS_FILTER))
        filter_d = req_in.wdata;
      if (wr_hit(req_in, IDR_OFS_PATH))
        path_d = req_in.wdata;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      scale_q <= SCALE_DFLT;
    else
      scale_q <= scale_d;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      filter_q <= FILTER_DFLT;
    else
      filter_q <= filter_d;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      path_q <= IDR_PATH_RST;
    else
      path_q <= path_d;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      temp_q <= 8'h00;
    else if (upd)
      temp_q <= src.temp;
  end

  // Per-axis lock, data and fresh flag
  genvar g;
  for (g = 0; g < 3; g++)
  begin : g_axis
    logic rd_low;
    logic rd_high;
    logic fresh_d;
    logic [15:0] pend_q;
    idr_lock_t lock_d;
    assign rd_low = rd_hit(req_in, IDR_OFS_X_LOW + 8'(2 * g));
    assign rd_high = rd_hit(req_in, IDR_OFS_X_HIGH + 8'(2 * g));

    // Lock engages only while shadowing is enabled
    always_comb
    begin
      lock_d = lock_q[g];
      case (lock_q[g])
        IDR_LOCK_OPEN:
        begin
          if (rd_low && lock_en)
            lock_d = IDR_LOCK_HELD;
        end
        IDR_LOCK_HELD:
        begin
          if (rd_high || !lock_en)
            lock_d = IDR_LOCK_OPEN;
        end
        default:
          lock_d = IDR_LOCK_OPEN;
      endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        lock_q[g] <= IDR_LOCK_OPEN;
      else
        lock_q[g] <= lock_d;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        low_q[g] <= 16'h0000;
      else if (upd)
        low_q[g] <= axis[g];
    end

    // Newest sample parked while the high byte is held
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        pend_q <= 16'h0000;
      else if (upd)
        pend_q <= axis[g];
    end

    // Held high byte keeps the pair coherent except when a sample lands in the low-byte read cycle; it catches up once released
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        high_q[g] <= 16'h0000;
      else if (lock_q[g] != IDR_LOCK_HELD || lock_d == IDR_LOCK_OPEN)
      begin
        if (upd)
          high_q[g] <= axis[g];
        else
          high_q[g] <= pend_q;
      end
    end

    // New sample in the read cycle wins, so no sample goes unflagged
    always_comb
    begin
      fresh_d = fresh_q[g];
      if (rd_low || rd_high)
        fresh_d = 1'b0;
      if (upd)
        fresh_d = 1'b1;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        fresh_q[g] <= 1'b0;
      else
        fresh_q[g] <= fresh_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rdata_out <= 8'h00;
    else if (req_in.rd)
    begin
      rdata_out <= read_word(req_in.addr);
    end
  end
endmodule

//--- dv/idr_top_checker.sv
// Port assertions for the readout block
`timescale 1ns/1ps
module idr_top_checker
  import idr_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic rstn_in, // Reset
  input wire idr_req_t lin_req_in, // Lin req
  input wire idr_req_t rot_req_in, // Rot req
  input wire logic [4:0] lin_bw_code_out, // Lin bw
  input wire logic [3:0] lin_range_code_out, // Lin range
  input wire logic [3:0] rot_bw_code_out, // Rot bw
  input wire logic [2:0] rot_range_code_out, // Rot range
  input wire logic lin_soft_reset_out, // Lin pulse
  input wire logic rot_soft_reset_out // Rot pulse
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  sequence s_lin_key;
    lin_req_in.wr && lin_req_in.addr == 8'h14 && lin_req_in.wdata == 8'hB6;
  endsequence
  sequence s_rot_key;
    rot_req_in.wr && rot_req_in.addr == 8'h14 && rot_req_in.wdata == 8'hB6;
  endsequence
  sequence s_lin_dflt;
    lin_range_code_out == 4'h3 && lin_bw_code_out == 5'h0F;
  endsequence
  sequence s_rot_dflt;
    rot_range_code_out == 3'h0 && rot_bw_code_out == 4'h0;
  endsequence
  property p_lin_key;
    s_lin_key |=> lin_soft_reset_out ##1 !lin_soft_reset_out;
  endproperty
  a_lin_key: assert property (p_lin_key) else $error("lin pulse bad");
  property p_rot_key;
    s_rot_key |=> rot_soft_reset_out ##1 !rot_soft_reset_out;
  endproperty
  a_rot_key: assert property (p_rot_key) else $error("rot pulse bad");
  property p_lin_dflt;
    lin_soft_reset_out |=> s_lin_dflt;
  endproperty
  a_lin_dflt: assert property (p_lin_dflt) else $error("lin defaults");
  property p_rot_dflt;
    rot_soft_reset_out |=> s_rot_dflt;
  endproperty
  a_rot_dflt: assert property (p_rot_dflt) else $error("rot defaults");
  property p_boot;
    $rose(rstn_in) |-> s_lin_dflt and s_rot_dflt;
  endproperty
  a_boot: assert property (p_boot) else $error("boot defaults");
  // Writes landing in the soft reset cycle are lost by design
  property p_lin_rng;
    lin_req_in.wr && lin_req_in.addr == 8'h0F && !lin_soft_reset_out
      |=> lin_range_code_out == $past(lin_req_in.wdata[3:0]);
  endproperty
  a_lin_rng: assert property (p_lin_rng) else $error("lin range");
  property p_rot_bw;
    rot_req_in.wr && rot_req_in.addr == 8'h10 && !rot_soft_reset_out
      |=> rot_bw_code_out == $past(rot_req_in.wdata[3:0]);
  endproperty
  a_rot_bw: assert property (p_rot_bw) else $error("rot bw");
  property p_rot_rng;
    rot_req_in.wr && rot_req_in.addr == 8'h0F && !rot_soft_reset_out
      |=> rot_range_code_out == $past(rot_req_in.wdata[2:0]);
  endproperty
  a_rot_rng: assert property (p_rot_rng) else $error("rot range");
endmodule

//--- dv/idr_host.sv
// Host register master model for both sensing units
`timescale 1ns/1ps
module idr_host
  import idr_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic [7:0] lin_rdata_in, // Lin data
  input wire logic [7:0] rot_rdata_in, // Rot data
  output idr_req_t lin_req_out, // Lin req
  output idr_req_t rot_req_out // Rot req
);
  initial lin_req_out = '0;
  initial rot_req_out = '0;
  task automatic go(input logic u, input idr_req_t v);
    @(posedge clk_in);
    if (u)
      rot_req_out <= v;
    else
      lin_req_out <= v;
    @(posedge clk_in);
    lin_req_out <= '0;
    rot_req_out <= '0;
  endtask
  task automatic wr(input logic u, input logic [7:0] a, input logic [7:0] d);
    go(u, {1'b1, 1'b0, a, d});
  endtask
  task automatic rd(input logic u, input logic [7:0] a, output logic [7:0] d);
    go(u, {1'b0, 1'b1, a, 8'h00});
    #1 d = u ? rot_rdata_in : lin_rdata_in;
  endtask
  // High byte always follows so a held lock is released
  task automatic rd_axis(input logic u, input logic [7:0] a, output logic [7:0] l,
    output logic [7:0] h);
    rd(u, a, l);
    rd(u, a + 8'h01, h);
  endtask
endmodule

//--- dv/inertial_data_regs_bench.sv
// Self-checking bench for the register readout block
`timescale 1ns/1ps
module inertial_data_regs_bench
  import idr_pkg::*;
  ;
  logic clk_in, rstn_in, lin_filt_valid_in, rot_filt_valid_in;
  logic lin_soft_reset_out, rot_soft_reset_out;
  idr_req_t lin_req_in, rot_req_in;
  idr_sample_t lin_raw_in, lin_filt_in, rot_raw_in, rot_filt_in, lf, rf, pl, pr;
  logic [7:0] lin_rdata_out, rot_rdata_out, l, h;
  logic [4:0] lin_bw_code_out;
  logic [3:0] lin_range_code_out, rot_bw_code_out;
  logic [2:0] rot_range_code_out;
  logic [31:0] seed = 32'h16;
  int bad_count = 0;
  int num_checks = 0;
  localparam logic [7:0] LR [4] = '{8'h03, 8'h05, 8'h08, 8'h0C};
  idr_top i_idr_top (.clk_in, .rstn_in, .lin_req_in, .rot_req_in, .lin_raw_in, .lin_filt_in,
    .lin_filt_valid_in, .rot_raw_in, .rot_filt_in, .rot_filt_valid_in, .lin_rdata_out,
    .rot_rdata_out, .lin_bw_code_out, .lin_range_code_out, .rot_bw_code_out,
    .rot_range_code_out, .lin_soft_reset_out, .rot_soft_reset_out);
  idr_host i_idr_host (.clk_in, .lin_rdata_in(lin_rdata_out), .rot_rdata_in(rot_rdata_out),
    .lin_req_out(lin_req_in), .rot_req_out(rot_req_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic w(input logic u, input logic [7:0] a, input logic [7:0] d);
    i_idr_host.wr(u, a, d);
  endtask
  task automatic r(input logic u, input logic [7:0] a, input logic [7:0] e);
    i_idr_host.rd(u, a, l);
    chk(l, e);
  endtask
  task automatic load();
    logic [31:0] a, b;
    a = xs();
    b = xs();
    lf = {{4{a[11]}}, a[11:0], {4{a[23]}}, a[23:12], {4{b[11]}}, b[11:0], b[31:24]};
    rf = {a, b[23:0]};
    @(posedge clk_in);
    lin_filt_in <= lf;
    rot_filt_in <= rf;
    lin_filt_valid_in <= 1'b1;
    rot_filt_valid_in <= 1'b1;
    @(posedge clk_in);
    lin_filt_valid_in <= 1'b0;
    rot_filt_valid_in <= 1'b0;
  endtask
  task automatic axis(input int i);
    logic [15:0] lv, rv;
    lv = lf[55 - 16 * i -: 16];
    rv = rf[55 - 16 * i -: 16];
    i_idr_host.rd_axis(1'b0, 8'(2 + 2 * i), l, h);
    chk(l & 8'hF1, {lv[3:0], 4'h1});
    chk(h, lv[11:4]);
    i_idr_host.rd_axis(1'b1, 8'(2 + 2 * i), l, h);
    chk({h, l}, rv);
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    rstn_in = 1'b0;
    {lin_raw_in, lin_filt_in, rot_raw_in, rot_filt_in} = '0;
    {lin_filt_valid_in, rot_filt_valid_in} = '0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    r(0, IDR_OFS_SCALE, IDR_LIN_SCALE_RST);
    r(0, IDR_OFS_FILTER, IDR_LIN_FILTER_RST);
    r(1, IDR_OFS_PATH, IDR_PATH_RST);
    repeat (5)
    begin
      load();
      for (int i = 0; i < 3; i++)
        axis(i);
      r(0, IDR_OFS_THERMAL, lf.temp);
      r(1, IDR_OFS_THERMAL, rf.temp);
    end
    i_idr_host.rd_axis(1'b0, IDR_OFS_X_LOW, l, h);
    chk(l[0], 1'b0);
    load();
    pl = lf;
    pr = rf;
    i_idr_host.rd(1'b0, IDR_OFS_X_LOW, l);
    i_idr_host.rd(1'b1, IDR_OFS_X_LOW, l);
    load();
    axis(1);
    r(0, IDR_OFS_X_HIGH, pl.x[11:4]);
    r(1, IDR_OFS_X_HIGH, pr.x[15:8]);
    w(0, IDR_OFS_PATH, 8'h40);
    w(1, IDR_OFS_PATH, 8'h40);
    i_idr_host.rd(1'b0, IDR_OFS_X_LOW, l);
    i_idr_host.rd(1'b1, IDR_OFS_X_LOW, l);
    load();
    r(0, IDR_OFS_X_HIGH, lf.x[11:4]);
    r(1, IDR_OFS_X_HIGH, rf.x[15:8]);
    w(0, IDR_OFS_PATH, 8'h80);
    w(1, IDR_OFS_PATH, 8'h80);
    lin_raw_in <= {16'hF800, 16'h07FF, 16'h0000, 8'h80};
    rot_raw_in <= {16'h8000, 16'h7FFF, 16'hFFFF, 8'h7F};
    load();
    // Spans at least one 2 kHz tick; filtered strobe must be ignored
    repeat (5100) @(posedge clk_in);
    lf = lin_raw_in;
    rf = rot_raw_in;
    for (int i = 0; i < 3; i++)
      axis(i);
    for (int i = 0; i < 8; i++)
    begin
      w(0, IDR_OFS_FILTER, 8'(8 + i));
      @(negedge clk_in);
      chk(lin_bw_code_out, 5'(8 + i));
      w(1, IDR_OFS_FILTER, 8'(i));
      r(1, IDR_OFS_FILTER, 8'(i));
    end
    for (int i = 0; i < 5; i++)
    begin
      w(0, IDR_OFS_SCALE, LR[(i + 1) % 4]);
      r(0, IDR_OFS_SCALE, LR[(i + 1) % 4]);
      w(1, IDR_OFS_SCALE, 8'(i));
      r(1, IDR_OFS_SCALE, 8'(i));
    end
    w(0, IDR_OFS_SOFT_RESET, 8'hB5);
    r(0, IDR_OFS_SCALE, 8'h05);
    w(0, IDR_OFS_SOFT_RESET, IDR_SOFT_RESET_KEY);
    w(1, IDR_OFS_SOFT_RESET, IDR_SOFT_RESET_KEY);
    // Shortened settle time after soft reset
    repeat (4) @(posedge clk_in);
    r(0, IDR_OFS_SCALE, IDR_LIN_SCALE_RST);
    r(0, IDR_OFS_PATH, IDR_PATH_RST);
    r(1, IDR_OFS_SCALE, IDR_ROT_SCALE_RST);
    r(1, IDR_OFS_PATH, IDR_PATH_RST);
    r(0, 8'h20, 8'h00);
    print_verdict();
  end
endmodule

bind idr_top idr_top_checker i_idr_top_checker (.clk_in, .rstn_in, .lin_req_in, .rot_req_in,
  .lin_bw_code_out, .lin_range_code_out, .rot_bw_code_out, .rot_range_code_out,
  .lin_soft_reset_out, .rot_soft_reset_out);
